/* logic/float_status_trap_logic.sv */
// Status register, exception detection and host word handshake of a float coprocessor.
// Assumes synchronous inputs on clk_in and an APB master for software access.
//
// Notes on behaviour
// RULE_01 - Conversion result wider than 56 (long) or 24 (short) bits sets status bit 0.
// RULE_02 - Status bits 1, 2, 3 hold overflow, zero and negative condition codes.
// RULE_03 - Bit 4 selects maintenance configuration; settable only in host kernel mode.
// RULE_04 - Bit 5 set truncates results; clear means rounding.
// RULE_05 - Conversion trap request is enable bit 8 AND conversion error flag.
// RULE_06 - Overflow trap request is enable bit 9 AND overflow flag.
// RULE_07 - Underflow interrupts only when enable bit 10 is set.
// RULE_08 - Minus-zero memory operand interrupts only when enable bit 11 is set.
// RULE_09 - Bit 14 set suppresses every float interrupt.
// RULE_10 - Microprogram error state sets error flag bit 15.
// RULE_11 - Negative sign with zero exponent sets minus-zero detect; trap vector 20.
// RULE_12 - Exponent bits 30 to 23 all zero gives zero flag in both polarities.
// RULE_13 - Request line asks for more words; sync without request ends the cycles.
// RULE_14 - Sync flop set means sync goes out in TS2 of the next microstate.
// RULE_15 - Direction line high requests a write, low a read.
// RULE_16 - Acknowledge-wait sets pause, waits asserting trap until host acknowledges.
// RULE_17 - Attention-wait waits until the host raises attention.
// RULE_18 - Operand address steps by 2 between word transfers on command.
// RULE_19 - Instruction bits 15 to 12 not all ones flags an illegal opcode.
// RULE_20 - Host init or interrupt-clear arms enable; init flop sets at TP2, clears address reg.
// RULE_21 - Control-select 0 loads the status register, 1 loads microbreak control.
// RULE_22 - Step counter loads at TP4 on command.
// RULE_23 - Host attention sets attention flop, clearing pause and leaving wait.
// RULE_24 - Trap requests raised while globally disabled are dropped, never held; code drops only underflow, flag-held ones return when bit 14 clears.
//
// Local design decisions: the register addresses and register access over APB.
`timescale 1ns/1ps
`default_nettype none
module float_status_trap_logic #(
    parameter int ADDR_W = 12
) (
    // Clock and reset
    input  wire logic                         clk_in,
    input  wire logic                         rst_in,
    // APB slave
    input  wire float_status_pkg::apb_req_t   apb_in,
    output logic [31:0]                       prdata_out,
    output logic                              pready_out,
    output logic                              pslverr_out,
    // Sequencer and datapath
    input  wire float_status_pkg::micro_t     micro_in,
    input  wire logic [15:0]                  data_in,
    input  wire logic [5:0]                   sc_value_in,
    input  wire logic [2:0]                   cc_value_in,
    input  wire logic [31:0]                  scratch_in,
    input  wire logic [63:0]                  conv_mag_in,
    input  wire logic [15:0]                  instr_in,
    // Host processor
    input  wire logic                         kernel_mode_in,
    input  wire logic                         cpu_trap_acknowledge_in,
    input  wire logic                         cpu_attention_line_in,
    input  wire logic                         cpu_init_in,
    input  wire logic                         cpu_intr_clr_in,
    output float_status_pkg::link_out_t       link_out,
    output logic [15:0]                       operand_addr_out,
    // Status toward the datapath and sequencer
    output logic [15:0]                       float_status_register_out,
    output logic                              truncate_select_bit_out,
    output logic                              maintenance_config_bit_out,
    output logic                              trap_request_out,
    output logic [7:0]                        trap_vector_out,
    output logic                              exponent_zero_detect_out,
    output logic                              exponent_zero_detect_n_out,
    output logic                              illegal_opcode_flag_out,
    output logic [7:0]                        control_store_address_reg_out,
    output logic [7:0]                        microbreak_out,
    output logic [5:0]                        step_counter_out,
    output float_status_pkg::tstate_t         time_state_out
);
    import float_status_pkg::*;

    // ****************************************
    // Parameter check
    // ****************************************
    if (ADDR_W < 12) begin : g_bad_width
        $error("ADDR_W must be at least 12");
    end

    // ****************************************
    // State
    // ****************************************
    typedef struct packed {
        tstate_t     ts;
        logic        pause;
        logic        wait_ack;
        logic        attn;
        logic        sync;
        logic        req;
        logic        dir;
        logic [15:0] sr;
        logic [7:0]  ubreak;
        logic [7:0]  control_store_address_reg;
        logic [15:0] addr;
        logic [5:0]  sc;
        logic        mz;
        logic        expz;
        logic        ill;
        logic        init_sync_enable;
        logic        sync_init_flop;
        logic [31:0] rdata;
    } state_t;

    state_t st_r;
    state_t st_nxt;
    logic   tp2;
    logic   tp4;
    logic   wr_en;
    logic   mapped;
    logic   exp_zero;
    logic   conv_err;
    logic   trap_any;
    logic   mz_trap;

    // Decodes shared by the next-state logic and the outputs
    assign tp2      = (st_r.ts == TS2);
    assign tp4      = (st_r.ts == TS4);
    assign mapped   = (apb_in.paddr == ADDR_STATUS) || (apb_in.paddr == ADDR_STATE) || (apb_in.paddr == ADDR_OPADR);
    assign wr_en    = apb_in.psel && apb_in.penable && apb_in.pwrite && (apb_in.paddr == ADDR_STATUS);
    assign exp_zero = (scratch_in[EXP_MSB:EXP_LSB] == 8'h00); // RULE_12
    assign conv_err = micro_in.conv_long ? (|conv_mag_in[63:LONG_BITS]) : (|conv_mag_in[63:SHORT_BITS]); // RULE_01
    assign mz_trap  = st_r.mz && st_r.sr[SR_MZ_EN] && !st_r.sr[SR_DISABLE]; // RULE_08

    // Trap requests are combinational: a disabled underflow is lost, held flags re-raise the rest once bit 14 clears
    assign trap_any = !st_r.sr[SR_DISABLE] && ( // RULE_09 RULE_24
        (st_r.sr[SR_CONV_EN] && st_r.sr[SR_CONV]) || // RULE_05
        (st_r.sr[SR_OVF_EN] && st_r.sr[SR_OVF]) || // RULE_06
        (st_r.sr[SR_UNF_EN] && micro_in.unf_event && tp4) || // RULE_07
        (st_r.sr[SR_MZ_EN] && st_r.mz)); // RULE_08

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        st_nxt = st_r;
        // Time-state sequencing with the wait between TS2 and TS3
        case (st_r.ts)
            TS1: st_nxt.ts = TS2;
            TS2: st_nxt.ts = st_r.pause ? TSW : TS3;
            TS3: st_nxt.ts = TS4;
            TS4: st_nxt.ts = TS1;
            TSW: begin
                if ((st_r.wait_ack && cpu_trap_acknowledge_in) || st_r.attn) begin // RULE_16 RULE_17
                    st_nxt.ts    = TS3;
                    st_nxt.pause = 1'b0;
                    st_nxt.attn  = 1'b0;
                end
            end
            default: st_nxt.ts = TS1;
        endcase
        // Attention is remembered until the wait consumes it
        if (cpu_attention_line_in) begin
            st_nxt.attn = 1'b1; // RULE_23
        end
        if (st_r.attn) begin
            st_nxt.pause = 1'b0; // RULE_23
        end
        // Sync goes out during TS2 and is then spent
        if (tp2) begin
            st_nxt.sync = 1'b0; // RULE_14
        end
        // APB write to the status register; bit 4 needs kernel mode
        if (wr_en) begin
            st_nxt.sr = apb_in.pwdata[15:0] & SR_WMASK;
            if (!kernel_mode_in) begin
                st_nxt.sr[SR_MAINT] = st_r.sr[SR_MAINT]; // RULE_03
            end
        end
        // Microcommands take effect at TP4
        if (tp4) begin
            case (micro_in.ctl_sel)
                CTL_LOAD_STATUS: begin
                    st_nxt.sr = data_in & SR_WMASK; // RULE_21
                    if (!kernel_mode_in) begin
                        st_nxt.sr[SR_MAINT] = st_r.sr[SR_MAINT]; // RULE_03
                    end
                end
                CTL_LOAD_UBREAK: st_nxt.ubreak = data_in[7:0]; // RULE_21
                default: st_nxt.ubreak = st_r.ubreak;
            endcase
            if (micro_in.cc_load) begin
                st_nxt.sr[SR_NEG:SR_OVF] = cc_value_in; // RULE_02
            end
            if (micro_in.set_sync || mz_trap) begin
                st_nxt.sync = 1'b1; // RULE_14
            end
            if (micro_in.set_req) begin
                st_nxt.req = 1'b1; // RULE_13
            end else if (micro_in.clr_req) begin
                st_nxt.req = 1'b0; // RULE_13
            end
            st_nxt.dir = micro_in.dir_write; // RULE_15
            if (micro_in.adr_load) begin
                st_nxt.addr = data_in;
            end else if (micro_in.adr_inc) begin
                st_nxt.addr = st_r.addr + ADDR_STEP; // RULE_18
            end
            if (micro_in.ack_wait || micro_in.attn_wait) begin
                st_nxt.pause    = 1'b1; // RULE_16 RULE_17
                st_nxt.wait_ack = micro_in.ack_wait;
            end
            if (micro_in.ld_sc) begin
                st_nxt.sc = sc_value_in; // RULE_22
            end
            if (micro_in.mz_check) begin
                st_nxt.mz = scratch_in[31] && exp_zero; // RULE_11
            end
            st_nxt.control_store_address_reg = micro_in.next_addr;
            st_nxt.expz = exp_zero; // RULE_12
            st_nxt.ill  = (instr_in[15:12] != OPCODE_GROUP); // RULE_19
            // Hardware sets win over any clear in the same cycle
            if (micro_in.conv_check && conv_err) begin
                st_nxt.sr[SR_CONV] = 1'b1; // RULE_01
            end
            if (micro_in.set_err) begin
                st_nxt.sr[SR_ERR] = 1'b1; // RULE_10
            end
        end
        // Init arms an enable; the flop itself sets at TP2
        if (cpu_init_in || cpu_intr_clr_in) begin
            st_nxt.init_sync_enable = 1'b1; // RULE_20
        end
        if (tp2) begin
            st_nxt.sync_init_flop = st_r.init_sync_enable; // RULE_20
            if (st_r.init_sync_enable && !(cpu_init_in || cpu_intr_clr_in)) begin
                st_nxt.init_sync_enable = 1'b0;
            end
        end
        if (st_r.sync_init_flop) begin
            st_nxt.control_store_address_reg = 8'h00; // RULE_20
        end
        // Read data is captured in the setup cycle
        if (apb_in.psel && !apb_in.penable) begin
            if (apb_in.paddr == ADDR_STATUS) begin
                st_nxt.rdata = {16'h0000, st_r.sr};
            end else if (apb_in.paddr == ADDR_STATE) begin
                st_nxt.rdata = {8'h00, st_r.control_store_address_reg, 2'h0, st_r.sc, st_r.sync_init_flop, st_r.ill,
                                st_r.mz, st_r.expz, st_r.req, st_r.pause, st_r.ts == TSW, 1'b0};
            end else if (apb_in.paddr == ADDR_OPADR) begin
                st_nxt.rdata = {16'h0000, st_r.addr};
            end else begin
                st_nxt.rdata = 32'h0000_0000;
            end
        end
    end

    // Register all state
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            st_r       <= '0;
            st_r.ts    <= TS1;
            st_r.sr    <= SR_RESET;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign prdata_out                    = st_r.rdata;
    assign pready_out                    = 1'b1;
    assign pslverr_out                   = apb_in.psel && apb_in.penable && !mapped;
    assign link_out.sync                 = st_r.sync && tp2; // RULE_14
    assign link_out.req                  = st_r.req; // RULE_13
    assign link_out.dir                  = st_r.dir; // RULE_15
    assign link_out.trap                 = (st_r.ts == TSW) && st_r.wait_ack; // RULE_16
    assign operand_addr_out              = st_r.addr;
    assign float_status_register_out     = st_r.sr;
    assign truncate_select_bit_out       = st_r.sr[SR_TRUNC]; // RULE_04
    assign maintenance_config_bit_out    = st_r.sr[SR_MAINT]; // RULE_03
    assign trap_request_out              = trap_any;
    assign trap_vector_out               = mz_trap ? MZ_VECTOR : 8'h00; // RULE_11
    assign exponent_zero_detect_out      = st_r.expz; // RULE_12
    assign exponent_zero_detect_n_out    = !st_r.expz; // RULE_12
    assign illegal_opcode_flag_out       = st_r.ill;
    assign control_store_address_reg_out = st_r.control_store_address_reg;
    assign microbreak_out                = st_r.ubreak;
    assign step_counter_out              = st_r.sc;
    assign time_state_out                = st_r.ts;

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);

    AST_CONV_SET: assert property (tp4 && micro_in.conv_check && !micro_in.conv_long && |conv_mag_in[63:24] |=> st_r.sr[0]) else $error("conversion error not flagged"); // RULE_01
    AST_CC_LOAD: assert property (tp4 && micro_in.cc_load && !wr_en && micro_in.ctl_sel != 3'h0 |=> st_r.sr[3:1] == $past(cc_value_in)) else $error("condition codes not loaded"); // RULE_02
    AST_MAINT_KERNEL: assert property ($rose(st_r.sr[4]) |-> $past(kernel_mode_in)) else $error("maintenance set outside kernel"); // RULE_03
    AST_TRUNC: assert property (truncate_select_bit_out == float_status_register_out[5]) else $error("truncate mismatch"); // RULE_04
    AST_CONV_TRAP: assert property (st_r.sr[8] && st_r.sr[0] && !st_r.sr[14] |-> trap_request_out) else $error("conversion trap missing"); // RULE_05
    AST_OVF_TRAP: assert property (st_r.sr[9] && st_r.sr[1] && !st_r.sr[14] |-> trap_request_out) else $error("overflow trap missing"); // RULE_06
    AST_DISABLE: assert property (st_r.sr[14] |-> !trap_request_out) else $error("trap while disabled"); // RULE_09
    AST_ERR: assert property (tp4 && micro_in.set_err |=> st_r.sr[15]) else $error("error flag not set"); // RULE_10
    AST_EXPZ: assert property (exponent_zero_detect_out != exponent_zero_detect_n_out) else $error("exponent zero polarity"); // RULE_12
    AST_SYNC_TS2: assert property (tp4 && micro_in.set_sync |-> ##2 link_out.sync) else $error("sync not sent in TS2"); // RULE_14
    AST_TRAP_WAIT: assert property (tp4 && micro_in.ack_wait && !st_r.attn && !cpu_attention_line_in |-> ##3 link_out.trap) else $error("no trap in wait"); // RULE_16
    AST_ADR_STEP: assert property (tp4 && micro_in.adr_inc && !micro_in.adr_load |=> operand_addr_out == $past(operand_addr_out) + 16'h0002) else $error("address step wrong"); // RULE_18
    AST_ILLEGAL: assert property (tp4 && instr_in[15:12] != 4'hf |=> illegal_opcode_flag_out) else $error("illegal opcode missed"); // RULE_19
    AST_INIT: assert property (st_r.sync_init_flop |=> control_store_address_reg_out == 8'h00) else $error("address reg not cleared"); // RULE_20
    AST_ATTN: assert property (st_r.ts == TSW && st_r.attn |=> st_r.ts == TS3 && !st_r.pause) else $error("attention ignored"); // RULE_23

    COV_ACK_WAIT: cover property (link_out.trap ##1 st_r.ts == TS3);
    COV_MZ_TRAP: cover property (trap_vector_out == 8'h14);
    COV_SYNC_NOREQ: cover property (link_out.sync && !link_out.req);
endmodule
`default_nettype wire

/* logic/float_status_pkg.sv */
// Constants and carriers for the float status and trap logic.
// Assumes one 10 MHz clock; the sequencer drives one microword per microstate.
package float_status_pkg;

    // Status register bit positions
    localparam int SR_CONV     = 0;
    localparam int SR_OVF      = 1;
    localparam int SR_ZERO     = 2;
    localparam int SR_NEG      = 3;
    localparam int SR_MAINT    = 4;
    localparam int SR_TRUNC    = 5;
    localparam int SR_CONV_EN  = 8;
    localparam int SR_OVF_EN   = 9;
    localparam int SR_UNF_EN   = 10;
    localparam int SR_MZ_EN    = 11;
    localparam int SR_DISABLE  = 14;
    localparam int SR_ERR      = 15;
    localparam logic [15:0] SR_RESET = 16'h0000;
    localparam logic [15:0] SR_WMASK = 16'hcf3f;

    // Register byte offsets
    localparam logic [11:0] ADDR_STATUS = 12'h000;
    localparam logic [11:0] ADDR_STATE  = 12'h004;
    localparam logic [11:0] ADDR_OPADR  = 12'h008;

    // Control-select codes, operand and conversion limits
    localparam logic [2:0]  CTL_LOAD_STATUS = 3'h0;
    localparam logic [2:0]  CTL_LOAD_UBREAK = 3'h1;
    localparam logic [7:0]  MZ_VECTOR       = 8'h14;  // Vector 20
    localparam logic [15:0] ADDR_STEP       = 16'h0002;
    localparam logic [3:0]  OPCODE_GROUP    = 4'hf;
    localparam int EXP_LSB    = 23;
    localparam int EXP_MSB    = 30;
    localparam int LONG_BITS  = 56;
    localparam int SHORT_BITS = 24;

    // Time states, Gray along TS1-TS2-TS3-TS4, wait off TS2
    typedef enum logic [2:0] {
        TS1 = 3'h0, TS2 = 3'h1, TS3 = 3'h3, TS4 = 3'h2, TSW = 3'h6
    } tstate_t;

    // Microword commands sampled at the end of each microstate
    typedef struct packed {
        logic [2:0] ctl_sel;
        logic       set_sync;
        logic       set_req;
        logic       clr_req;
        logic       dir_write;
        logic       adr_load;
        logic       adr_inc;
        logic       ack_wait;
        logic       attn_wait;
        logic       set_err;
        logic       ld_sc;
        logic       cc_load;
        logic       conv_check;
        logic       conv_long;
        logic       mz_check;
        logic       unf_event;
        logic [7:0] next_addr;
    } micro_t;

    // APB request from the master
    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } apb_req_t;

    // Lines toward the host processor
    typedef struct packed {
        logic sync;
        logic req;
        logic dir;
        logic trap;
    } link_out_t;

endpackage

/* tb/host_cpu_model.sv */
// Host processor model on the far side of the coprocessor link.
// Assumes the bench clock and a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module host_cpu_model #(
    parameter int ACK_DELAY = 3
) (
    // Clock and reset
    input  wire logic clk_in,
    input  wire logic rst_in,
    // Trap line and bench attention command
    input  wire logic trap_in,
    input  wire logic attn_cmd_in,
    // Host answers
    output logic      ack_out,
    output logic      attn_out
);
    int cnt;
    // Acknowledge a trap after a delay, hold it until the trap drops
    always @(posedge clk_in) begin
        if (rst_in || !trap_in) begin
            cnt <= 0;
            ack_out <= 1'b0;
        end else if (cnt < ACK_DELAY) begin
            cnt <= cnt + 1;
        end else begin
            ack_out <= 1'b1;
        end
    end
    // Attention follows the bench command one cycle late
    always @(posedge clk_in) begin
        attn_out <= attn_cmd_in & ~rst_in;
    end
endmodule
`default_nettype wire

/* tb/float_status_trap_logic_tb_top.sv */
// Self-checking bench for the float status and trap logic.
// Assumes the package, the design and the host model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module float_status_trap_logic_tb_top;
    import float_status_pkg::*;
    localparam micro_t          IDLE = '{ctl_sel: 3'h7, default: '0};
    localparam logic [15:0]     TV [10] = '{16'h0101, 16'h0001, 16'h4101, 16'h0202, 16'h0002,
                                            16'h4202, 16'h0400, 16'h0000, 16'h4400, 16'h0400};
    localparam logic [9:0]      TU = 10'h1c0;
    localparam logic [9:0]      TX = 10'h049;
    logic        clk_in, rst_in, kernel, cpu_init, cpu_init_sync_enable, attn_cmd, ack, attn;
    logic        pready_out, pslverr_out, tsb, mcb, trap_req, expz, expz_n, ill, tr, e;
    logic [15:0] data_in, instr_in, op_addr, sr;
    logic [5:0]  sc_value_in, sc;
    logic [2:0]  cc_value_in;
    logic [31:0] scratch_in, prdata_out, q;
    logic [63:0] conv_mag_in;
    logic [7:0]  vec, control_store_address_reg, ubrk;
    apb_req_t    apb_in;
    micro_t      micro_in, m;
    link_out_t   link_out;
    tstate_t     ts;
    int          num_errors = 0;
    int          n_checks = 0;
    int          n;

    float_status_trap_logic float_status_trap_logic_inst (
        .clk_in(clk_in), .rst_in(rst_in), .apb_in(apb_in), .prdata_out(prdata_out),
        .pready_out(pready_out), .pslverr_out(pslverr_out), .micro_in(micro_in), .data_in(data_in),
        .sc_value_in(sc_value_in), .cc_value_in(cc_value_in), .scratch_in(scratch_in),
        .conv_mag_in(conv_mag_in), .instr_in(instr_in), .kernel_mode_in(kernel),
        .cpu_trap_acknowledge_in(ack), .cpu_attention_line_in(attn), .cpu_init_in(cpu_init),
        .cpu_intr_clr_in(cpu_init_sync_enable), .link_out(link_out), .operand_addr_out(op_addr),
        .float_status_register_out(sr), .truncate_select_bit_out(tsb), .maintenance_config_bit_out(mcb),
        .trap_request_out(trap_req), .trap_vector_out(vec), .exponent_zero_detect_out(expz),
        .exponent_zero_detect_n_out(expz_n), .illegal_opcode_flag_out(ill),
        .control_store_address_reg_out(control_store_address_reg), .microbreak_out(ubrk), .step_counter_out(sc),
        .time_state_out(ts));
    host_cpu_model host_cpu_model_inst (.clk_in(clk_in), .rst_in(rst_in), .trap_in(link_out.trap),
        .attn_cmd_in(attn_cmd), .ack_out(ack), .attn_out(attn));

    // ****************************************
    // Clock, timeout and tasks
    // ****************************************
    initial begin
        clk_in = 1'b0;
        forever #50 clk_in = ~clk_in;
    end
    // Cut a hung run short
    initial begin
        repeat (5000) @(posedge clk_in);
        num_errors++;
        $display("BAD %0t: timeout", $time);
        end_of_test();
    end
    task automatic end_of_test();
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] x);
        n_checks++;
        if (g !== x) begin
            num_errors++;
            $display("BAD %0t: got %h expected %h", $time, g, x);
        end
    endtask
    // One APB transfer; holds the request until pready is seen
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        apb_in <= '{1'b1, 1'b0, w, a, d};
        @(posedge clk_in);
        apb_in.penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_in);
            n++;
        end while (pready_out !== 1'b1 && n < 20);
        q = prdata_out;
        e = pslverr_out;
        chk(pready_out, 1'b1);
        apb_in <= '0;
        @(posedge clk_in);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] x);
        apb(1'b0, a, '0);
        chk(q, x);
    endtask
    task automatic wr(input logic [15:0] d);
        apb(1'b1, ADDR_STATUS, {16'h0, d});
    endtask
    // Present a microword for one TS4 cycle; tr keeps the trap request seen then
    task automatic uw(input micro_t mi);
        n = 0;
        do begin
            @(posedge clk_in);
            n++;
        end while (ts !== TS3 && n < 40);
        micro_in <= mi;
        @(posedge clk_in);
        tr = trap_req;
        micro_in <= IDLE;
    endtask

    // ****************************************
    // Test sequence
    // ****************************************
    initial begin
        rst_in = 1'b1;
        apb_in = '0;
        micro_in = IDLE;
        data_in = '0;
        sc_value_in = '0;
        cc_value_in = '0;
        scratch_in = 32'h3f80_0000;
        conv_mag_in = '0;
        instr_in = 16'hf000;
        {kernel, cpu_init, cpu_init_sync_enable, attn_cmd} = '0;
        repeat (3) @(posedge clk_in);
        rst_in <= 1'b0;
        @(posedge clk_in);
        rd(ADDR_STATUS, {16'h0, SR_RESET});
        apb(1'b1, ADDR_STATUS, '1);
        rd(ADDR_STATUS, {16'h0, SR_WMASK & 16'hffef});
        kernel <= 1'b1;
        apb(1'b1, ADDR_STATUS, '1);
        rd(ADDR_STATUS, {16'h0, SR_WMASK});
        chk({tsb, mcb}, 2'h3);
        wr(16'h0000);
        chk({tsb, mcb}, 2'h0);
        apb(1'b0, 12'h00c, '0);
        chk(q, 32'h0000_0000);
        chk(e, 1'b1);
        $display("done: registers");
        for (int i = 0; i < 10; i++) begin
            wr(TV[i]);
            m = IDLE;
            m.unf_event = TU[i];
            uw(m);
            chk(tr, TX[i]);
        end
        $display("done: trap requests");
        wr(16'h0000);
        m = IDLE;
        m.cc_load = 1'b1;
        cc_value_in <= 3'h5;
        uw(m);
        rd(ADDR_STATUS, 32'h0000_000a);
        for (int i = 0; i < 4; i++) begin
            wr(16'h0000);
            m = IDLE;
            m.conv_check = 1'b1;
            m.conv_long = (i < 2);
            conv_mag_in <= (64'h1 << (i < 2 ? LONG_BITS : SHORT_BITS)) - 64'(i % 2);
            uw(m);
            rd(ADDR_STATUS, 32'(i % 2 == 0));
        end
        wr(16'h0000);
        m = IDLE;
        m.set_err = 1'b1;
        uw(m);
        rd(ADDR_STATUS, 32'h0000_8000);
        $display("done: status flags");
        data_in <= 16'h0325;
        sc_value_in <= 6'h2a;
        m = IDLE;
        m.ctl_sel = CTL_LOAD_STATUS;
        {m.ld_sc, m.adr_load, m.dir_write} = 3'h7;
        uw(m);
        @(posedge clk_in);
        chk(sc, 6'h2a);
        chk(link_out.dir, 1'b1);
        chk(sr, 16'h0325);
        rd(ADDR_STATUS, 32'h0000_0325);
        data_in <= 16'h00a5;
        m = IDLE;
        m.ctl_sel = CTL_LOAD_UBREAK;
        m.adr_inc = 1'b1;
        uw(m);
        @(posedge clk_in);
        chk(ubrk, 8'ha5);
        chk(op_addr, 16'h0325 + ADDR_STEP);
        rd(ADDR_OPADR, 32'h0000_0327);
        chk(link_out.dir, 1'b0);
        rd(ADDR_STATUS, 32'h0000_0325);
        m = IDLE;
        {m.set_sync, m.set_req} = 2'h3;
        uw(m);
        for (int i = 0; i < 3; i++) begin
            @(posedge clk_in);
            chk(link_out.sync, i == 1);
        end
        chk(link_out.req, 1'b1);
        m = IDLE;
        m.clr_req = 1'b1;
        uw(m);
        @(posedge clk_in);
        chk(link_out.req, 1'b0);
        $display("done: microword commands");
        m = IDLE;
        m.ack_wait = 1'b1;
        uw(m);
        n = 0;
        while (link_out.trap !== 1'b1 && n < 10) begin
            @(posedge clk_in);
            n++;
        end
        chk(ts, TSW);
        while (ts !== TS3 && n < 30) begin
            @(posedge clk_in);
            n++;
        end
        chk({ack, link_out.trap}, 2'h2);
        m = IDLE;
        m.attn_wait = 1'b1;
        uw(m);
        repeat (6) @(posedge clk_in);
        chk(ts, TSW);
        attn_cmd <= 1'b1;
        n = 0;
        while (ts !== TS3 && n < 10) begin
            @(posedge clk_in);
            n++;
        end
        attn_cmd <= 1'b0;
        chk(n < 10, 1'b1);
        $display("done: waits");
        wr(16'h0800);
        scratch_in <= 32'h8000_0000;
        m = IDLE;
        m.mz_check = 1'b1;
        uw(m);
        n = 0;
        while (vec !== MZ_VECTOR && n < 10) begin
            @(posedge clk_in);
            n++;
        end
        chk(vec, MZ_VECTOR);
        chk({expz, expz_n}, 2'h2);
        wr(16'h0000);
        chk(vec, 8'h00);
        scratch_in <= 32'h0080_0000;
        uw(m);
        repeat (4) @(posedge clk_in);
        chk(vec, 8'h00);
        chk({expz, expz_n}, 2'h1);
        instr_in <= 16'h7000;
        repeat (5) @(posedge clk_in);
        chk(ill, 1'b1);
        instr_in <= 16'hf000;
        repeat (5) @(posedge clk_in);
        chk(ill, 1'b0);
        $display("done: detectors");
        m = IDLE;
        m.next_addr = 8'h5a;
        micro_in <= m;
        repeat (5) @(posedge clk_in);
        chk(control_store_address_reg, 8'h5a);
        cpu_init <= 1'b1;
        @(posedge clk_in);
        cpu_init <= 1'b0;
        repeat (6) @(posedge clk_in);
        chk(control_store_address_reg, 8'h00);
        $display("done: init");
        end_of_test();
    end
endmodule
`default_nettype wire
